// ==== uart_sfr_consts.svh ====
// Offsets, field positions, reset values and key values of the special register bank.
`ifndef UART_REG_CONSTS_SVH
`define UART_REG_CONSTS_SVH

`define BANK_OFS_PRESCALE   4'h4
`define BANK_OFS_RX_COUNT   4'h5
`define BANK_OFS_TX_COUNT   4'h6
`define BANK_OFS_SPECIAL    4'h7
`define BANK_OFS_IDLE_TIME  4'h8
`define BANK_OFS_TXRX_CTRL  4'h9
`define BANK_OFS_UNLOCK_KEY 4'hD
`define BANK_OFS_INT_STATUS 4'hF

`define BANK_ENHANCED_MODE  8'hBF
`define BANK_UNLOCK_VALUE   8'h5A
`define BANK_FIFO_DEPTH     8'h40

`define BANK_RST_PRESCALE   8'h10
`define BANK_RST_TXRX_CTRL  8'h06
`define BANK_RST_ZERO       8'h00

`define SPC_BIT_XTAL_FB_DIS 7
`define SPC_BIT_CNT_SEL     6
`define SPC_BIT_BURST       4
`define SPC_BIT_LOOPBACK    3
`define SPC_BIT_SPECIAL_EN  2
`define SPC_BIT_AUTO_DSR    1
`define SPC_BIT_FORCE_TX    0

`define TRC_BIT_XON_INBAND  3
`define TRC_BIT_TX_EMPTY    2
`define TRC_BIT_RX_TIMEOUT  1
`define TRC_BIT_IDLE_EN     0

`define ISR_BIT_CLEAR_ALL   0

`endif

// ==== uart_sfr_pkg.sv ====
// Types shared by the special register bank and its users.
package uart_reg_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       seq;
    logic [3:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic       xtal_fb_dis;
    logic       burst_en;
    logic       auto_dsr_dtr_en;
    logic [7:0] idle_time;
    logic       xon_inband_en;
    logic       tx_empty_int_en;
    logic       rx_timeout_en;
    logic [3:0] sample_clock_value;
    logic [3:0] prescale_exponent;
    logic [3:0] prescale_fraction;
  } uart_ctrl_t;

endpackage : uart_reg_pkg

// ==== uart_special_function_regs.sv ====
// Special function register bank of one bridge UART channel.
//
// Functional notes
// - Extended registers need enhanced mode and access bit.
// - Special register needs enhanced mode and unlock key.
// - Bit six selects fill or error count.
// - Receive fill count reports bytes held.
// - Error count reports erroneous bytes held.
// - Transmit fill count reports bytes held.
// - Prescale holds exponent high, fraction low.
// - Baud generator follows the prescale divide formula.
// - Bit four enables burst register access.
// - Bit three loops receive data to transmit.
// - Bit one enables automatic DSR/DTR flow.
// - Bit zero forces continuous transmit.
// - Idle time applies only when enabled.
// - Control bit three enables in-band Xon.
// - Control bits two, one enable interrupt, timeout.
// - Status bits set while sources active.
// - Clear-all bit clears status, self-clears.
// - Registers take documented defaults at reset.
`timescale 1ns/1ps
`include "uart_sfr_consts.svh"

module uart_special_function_regs (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  input  wire uart_reg_pkg::host_req_t i_req,
  input  wire logic [7:0]              i_line_control_reg,
  input  wire logic                    i_modem_ctrl_bit7,
  input  wire logic [15:0]             i_baud_divisor,
  input  wire logic                    i_rx_push,
  input  wire logic                    i_rx_push_err,
  input  wire logic                    i_rx_pop,
  input  wire logic                    i_rx_pop_err,
  input  wire logic                    i_tx_push,
  input  wire logic                    i_tx_pop,
  input  wire logic [7:1]              i_int_src,
  input  wire logic                    i_tx_serial,
  input  wire logic                    i_rx_serial,
  input  wire logic                    i_flow_ok,
  input  wire logic                    i_dsr_n,
  output logic [7:0]                   o_rdata,
  output logic                         o_rvalid,
  output logic                         o_baud_tick,
  output logic                         o_tx_line,
  output logic                         o_tx_allowed,
  output uart_reg_pkg::uart_ctrl_t     o_ctrl
);

  // ********************************************************************
  // Helpers
  // ********************************************************************
  function automatic logic [7:0] count_step(input logic [7:0] cnt,
                                            input logic       inc,
                                            input logic       dec);
    logic [7:0] res;
    res = cnt;
    if (inc && !dec && cnt < `BANK_FIFO_DEPTH) begin
      res = cnt + 8'h01;
    end else if (dec && !inc && cnt != 8'h00) begin
      res = cnt - 8'h01;
    end
    return res;
  endfunction : count_step

  // Full divide count of one baud tick; zero means the generator stalls.
  function automatic logic [39:0] baud_limit(input logic [15:0] dvs,
                                             input logic [3:0]  m,
                                             input logic        mbit,
                                             input logic [3:0]  smp,
                                             input logic [3:0]  n);
    logic [5:0]  den;
    logic [4:0]  shift;
    logic [39:0] prod;
    den   = 6'h10 - {2'h0, smp} + {2'h0, n};
    shift = {1'h0, m} + {3'h0, mbit, 1'h0};
    prod  = {24'h0, dvs} * {34'h0, den};
    return (prod << shift) >> 1;
  endfunction : baud_limit

  // ********************************************************************
  // Registers and access decode
  // ********************************************************************
  logic [7:0]  prescale_reg;
  logic [7:0]  special_reg;
  logic [7:0]  idle_time_reg;
  logic [7:0]  txrx_ctrl_reg;
  logic [7:0]  unlock_key_reg;
  logic [7:1]  int_status_reg;
  logic [7:1]  int_status_next;
  logic [7:0]  rx_fill_reg;
  logic [7:0]  rx_err_reg;
  logic [7:0]  tx_fill_reg;
  logic [3:0]  last_addr_reg;
  logic [39:0] baud_cnt_reg;
  logic [39:0] limit;
  logic [3:0]  addr;
  logic        enhanced;
  logic        special_ok;
  logic        key_ok;
  logic        gated;
  logic        wr_ok;
  logic        rd_ok;

  assign enhanced   = i_line_control_reg == `BANK_ENHANCED_MODE;
  assign special_ok = enhanced && special_reg[`SPC_BIT_SPECIAL_EN];
  assign key_ok     = enhanced && unlock_key_reg == `BANK_UNLOCK_VALUE;

  // Burst access steps through consecutive offsets without a new address.
  assign addr = (special_reg[`SPC_BIT_BURST] && i_req.seq) ?
                last_addr_reg + 4'h1 : i_req.addr;

  always_comb begin
    case (addr)
      `BANK_OFS_PRESCALE, `BANK_OFS_RX_COUNT, `BANK_OFS_TX_COUNT,
      `BANK_OFS_IDLE_TIME, `BANK_OFS_TXRX_CTRL,
      `BANK_OFS_INT_STATUS: gated = special_ok;
      `BANK_OFS_SPECIAL:    gated = key_ok;
      `BANK_OFS_UNLOCK_KEY: gated = enhanced;
      default:             gated = 1'b0;
    endcase
  end

  assign wr_ok = i_req.wr && gated;
  assign rd_ok = i_req.rd && gated;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      last_addr_reg <= 4'h0;
    end else if (i_req.wr || i_req.rd) begin
      last_addr_reg <= addr;
    end
  end

  // ********************************************************************
  // Writable configuration
  // ********************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prescale_reg   <= `BANK_RST_PRESCALE;
      special_reg    <= `BANK_RST_ZERO;
      idle_time_reg  <= `BANK_RST_ZERO;
      txrx_ctrl_reg  <= `BANK_RST_TXRX_CTRL;
      unlock_key_reg <= `BANK_RST_ZERO;
    end else if (wr_ok) begin
      case (addr)
        `BANK_OFS_PRESCALE:   prescale_reg   <= i_req.wdata;
        `BANK_OFS_SPECIAL:    special_reg    <= i_req.wdata;
        `BANK_OFS_IDLE_TIME:  idle_time_reg  <= i_req.wdata;
        `BANK_OFS_TXRX_CTRL:  txrx_ctrl_reg  <= i_req.wdata;
        `BANK_OFS_UNLOCK_KEY: unlock_key_reg <= i_req.wdata;
        default:             unlock_key_reg <= unlock_key_reg;
      endcase
    end
  end

  // ********************************************************************
  // Interrupt status
  // ********************************************************************
  // An active source wins over a clear in the same cycle, so no event is lost.
  always_comb begin
    int_status_next = int_status_reg;
    if (wr_ok && addr == `BANK_OFS_INT_STATUS) begin
      if (i_req.wdata[`ISR_BIT_CLEAR_ALL]) begin
        int_status_next = 7'h00;
      end else begin
        int_status_next = i_req.wdata[7:1];
      end
    end
    int_status_next = int_status_next | i_int_src;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      int_status_reg <= 7'h00;
    end else begin
      int_status_reg <= int_status_next;
    end
  end

  // ********************************************************************
  // FIFO counters
  // ********************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_fill_reg <= 8'h00;
      rx_err_reg  <= 8'h00;
      tx_fill_reg <= 8'h00;
    end else begin
      rx_fill_reg <= count_step(rx_fill_reg, i_rx_push, i_rx_pop);
      rx_err_reg  <= count_step(rx_err_reg, i_rx_push && i_rx_push_err,
                                i_rx_pop && i_rx_pop_err);
      tx_fill_reg <= count_step(tx_fill_reg, i_tx_push, i_tx_pop);
    end
  end

  // ********************************************************************
  // Read port
  // ********************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata  <= 8'h00;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_req.rd;
      if (!rd_ok) begin
        o_rdata <= 8'h00;
      end else begin
        case (addr)
          `BANK_OFS_PRESCALE:   o_rdata <= prescale_reg;
          `BANK_OFS_RX_COUNT:   o_rdata <= special_reg[`SPC_BIT_CNT_SEL] ?
                                           rx_err_reg : rx_fill_reg;
          `BANK_OFS_TX_COUNT:   o_rdata <= tx_fill_reg;
          `BANK_OFS_SPECIAL:    o_rdata <= special_reg;
          `BANK_OFS_IDLE_TIME:  o_rdata <= idle_time_reg;
          `BANK_OFS_TXRX_CTRL:  o_rdata <= txrx_ctrl_reg;
          `BANK_OFS_UNLOCK_KEY: o_rdata <= unlock_key_reg;
          `BANK_OFS_INT_STATUS: o_rdata <= {int_status_reg, 1'b0};
          default:             o_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ********************************************************************
  // Baud generator
  // ********************************************************************
  // The divide is recomputed every cycle, so a new setting takes effect at
  // once; a tick may come early or late across the change.
  assign limit = baud_limit(i_baud_divisor, prescale_reg[7:4],
                            i_modem_ctrl_bit7, txrx_ctrl_reg[7:4],
                            prescale_reg[3:0]);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      baud_cnt_reg <= 40'h0;
      o_baud_tick  <= 1'b0;
    end else if (limit == 40'h0) begin
      baud_cnt_reg <= 40'h0;
      o_baud_tick  <= 1'b0;
    end else if (baud_cnt_reg >= limit - 40'h1) begin
      baud_cnt_reg <= 40'h0;
      o_baud_tick  <= 1'b1;
    end else begin
      baud_cnt_reg <= baud_cnt_reg + 40'h1;
      o_baud_tick  <= 1'b0;
    end
  end

  // ********************************************************************
  // Control outputs
  // ********************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ctrl <= '0;
    end else begin
      o_ctrl.xtal_fb_dis        <= special_reg[`SPC_BIT_XTAL_FB_DIS];
      o_ctrl.burst_en           <= special_reg[`SPC_BIT_BURST];
      o_ctrl.auto_dsr_dtr_en    <= special_reg[`SPC_BIT_AUTO_DSR];
      o_ctrl.idle_time          <= txrx_ctrl_reg[`TRC_BIT_IDLE_EN] ?
                                   idle_time_reg : 8'h00;
      o_ctrl.xon_inband_en      <= txrx_ctrl_reg[`TRC_BIT_XON_INBAND];
      o_ctrl.tx_empty_int_en    <= txrx_ctrl_reg[`TRC_BIT_TX_EMPTY];
      o_ctrl.rx_timeout_en      <= txrx_ctrl_reg[`TRC_BIT_RX_TIMEOUT];
      o_ctrl.sample_clock_value <= txrx_ctrl_reg[7:4];
      o_ctrl.prescale_exponent  <= prescale_reg[7:4];
      o_ctrl.prescale_fraction  <= prescale_reg[3:0];
    end
  end

  // Loopback and gating are combinational so the serial path adds no delay.
  assign o_tx_line = special_reg[`SPC_BIT_LOOPBACK] ?
                     i_rx_serial : i_tx_serial;
  assign o_tx_allowed = special_reg[`SPC_BIT_FORCE_TX] ||
                        (i_flow_ok && (!special_reg[`SPC_BIT_AUTO_DSR] ||
                                       !i_dsr_n));

  // ********************************************************************
  // Checks
  // ********************************************************************
  special_lock_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_req.wr && !special_ok && i_req.addr == `BANK_OFS_PRESCALE &&
     !(special_reg[`SPC_BIT_BURST] && i_req.seq)) |=> $stable(prescale_reg))
    else $error("Prescale written while locked.");

  special_unlock_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_ok && addr == `BANK_OFS_SPECIAL) |=> special_reg == $past(i_req.wdata))
    else $error("Special register write lost.");

  key_lock_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (unlock_key_reg != `BANK_UNLOCK_VALUE) |=> $stable(special_reg))
    else $error("Special register changed without key.");

  fill_select_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (rd_ok && addr == `BANK_OFS_RX_COUNT && !special_reg[`SPC_BIT_CNT_SEL])
    |=> o_rdata == $past(rx_fill_reg))
    else $error("Receive fill count not returned.");

  err_select_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (rd_ok && addr == `BANK_OFS_RX_COUNT && special_reg[`SPC_BIT_CNT_SEL])
    |=> o_rdata == $past(rx_err_reg))
    else $error("Error count not returned.");

  tx_fill_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (rd_ok && addr == `BANK_OFS_TX_COUNT) |=> o_rdata == $past(tx_fill_reg))
    else $error("Transmit fill count not returned.");

  fill_bound_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_rx_push && !i_rx_pop && rx_fill_reg < `BANK_FIFO_DEPTH)
    |=> rx_fill_reg == $past(rx_fill_reg) + 8'h01 &&
        rx_fill_reg <= `BANK_FIFO_DEPTH)
    else $error("Receive fill count wrong.");

  status_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_int_src[4] |=> int_status_reg[4])
    else $error("Status bit missed its source.");

  clear_all_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_ok && addr == `BANK_OFS_INT_STATUS && i_req.wdata[0] &&
     i_int_src == 7'h00) |=> int_status_reg == 7'h00)
    else $error("Clear-all left status set.");

  loopback_a: assert property (@(posedge i_clk) disable iff (i_rst)
    special_reg[`SPC_BIT_LOOPBACK] |-> o_tx_line == i_rx_serial)
    else $error("Loopback not applied.");

  force_tx_a: assert property (@(posedge i_clk) disable iff (i_rst)
    special_reg[`SPC_BIT_FORCE_TX] |-> o_tx_allowed)
    else $error("Forced transmit gated.");

  idle_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !txrx_ctrl_reg[`TRC_BIT_IDLE_EN] |=> o_ctrl.idle_time == 8'h00)
    else $error("Idle time applied while disabled.");

  burst_step_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (special_reg[`SPC_BIT_BURST] && i_req.seq && (i_req.wr || i_req.rd))
    |=> last_addr_reg == $past(last_addr_reg) + 4'h1)
    else $error("Burst access did not step the offset.");

endmodule : uart_special_function_regs

// ==== host_model.sv ====
// Host side model that issues register accesses on the bank's port.
`timescale 1ns/1ps

module host_model (
  input  wire logic                    i_clk,
  input  wire logic                    i_rvalid,
  input  wire logic [7:0]              i_rdata,
  output uart_reg_pkg::host_req_t      o_req
);
  initial o_req = '0;

  // Strobes are cleared and address and data inverted on release so stale values never look valid.
  task automatic acc(input logic w, input logic s, input logic [3:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(negedge i_clk);
    o_req <= {w, !w, s, a, d};
    @(negedge i_clk);
    q = w ? 8'h00 : (i_rvalid ? i_rdata : ~i_rdata);
    o_req <= {3'b000, ~a, ~d};
  endtask : acc

  task automatic unlock(input logic [7:0] sf);
    logic [7:0] q;
    acc(1'b1, 1'b0, 4'hD, 8'h5A, q);
    acc(1'b1, 1'b0, 4'h7, sf, q);
  endtask : unlock
endmodule : host_model

// ==== uart_special_function_regs_tb.sv ====
// Self-checking bench of the special function register bank.
`timescale 1ns/1ps

module uart_special_function_regs_tb;
  logic                       i_clk, i_rst, modem7, rxp, rxpe, rxo, rxoe;
  logic                       txp, txo, txs, rxs, flow, dsr_n, tick, txl;
  logic                       txa, rvalid;
  logic [7:0]                 line_ctl, rdata, seed, r, t;
  logic [15:0]                divisor;
  logic [7:1]                 src;
  uart_reg_pkg::host_req_t    req;
  uart_reg_pkg::uart_ctrl_t   ctrl;
  int                         errors, checked, cyc, errs, n;

  uart_special_function_regs DUT (.i_clk(i_clk), .i_rst(i_rst),
    .i_req(req), .i_line_control_reg(line_ctl), .i_modem_ctrl_bit7(modem7),
    .i_baud_divisor(divisor), .i_rx_push(rxp), .i_rx_push_err(rxpe),
    .i_rx_pop(rxo), .i_rx_pop_err(rxoe), .i_tx_push(txp), .i_tx_pop(txo),
    .i_int_src(src), .i_tx_serial(txs), .i_rx_serial(rxs),
    .i_flow_ok(flow), .i_dsr_n(dsr_n), .o_rdata(rdata), .o_rvalid(rvalid),
    .o_baud_tick(tick), .o_tx_line(txl), .o_tx_allowed(txa), .o_ctrl(ctrl));

  host_model host (.i_clk(i_clk), .i_rvalid(rvalid), .i_rdata(rdata),
    .o_req(req));

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // Hang guard, well above the few hundred cycles the run needs.
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end

  function automatic logic [7:0] nx();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction : nx

  function automatic logic [7:0] f_idle(input logic [7:0] trc, idle);
    return trc[0] ? idle : 8'h00;
  endfunction : f_idle

  function automatic logic [7:0] f_baud(input int d, m, k, s, f);
    return 8'(((d * (16 - s + f)) << (m + 2 * k)) >> 1);
  endfunction : f_baud

  task automatic chk(input logic [7:0] got, exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.acc(1'b1, 1'b0, a, d, q);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic s, input logic [7:0] e);
    logic [7:0] q;
    host.acc(1'b0, s, a, 8'h00, q);
    chk(q, e);
  endtask : rd

  task automatic complete_run();
    if (errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {modem7, rxp, rxpe, rxo, rxoe, txp, txo, txs, rxs, dsr_n} = '0;
    {errors, checked, cyc, errs} = '0;
    i_rst = 1'b1;
    flow = 1'b1;
    line_ctl = 8'h00;
    divisor = 16'h0001;
    src = 7'h00;
    seed = 8'h52;
    repeat (8) @(negedge i_clk);
    i_rst = 1'b0;
    rd(4'h4, 1'b0, 8'h00);
    line_ctl = 8'hBF;
    rd(4'h4, 1'b0, 8'h00);
    wr(4'h4, 8'hFF);
    rd(4'h7, 1'b0, 8'h00);
    host.unlock(8'h04);
    rd(4'h7, 1'b0, 8'h04);
    rd(4'h4, 1'b0, 8'h10);
    rd(4'h8, 1'b0, 8'h00);
    rd(4'h9, 1'b0, 8'h06);
    rd(4'hF, 1'b0, 8'h00);
    chk({6'h00, ctrl.tx_empty_int_en, ctrl.rx_timeout_en}, 8'h03);
    repeat (6) begin
      r = nx();
      wr(4'h4, r);
      rd(4'h4, 1'b0, r);
      chk({ctrl.prescale_exponent, ctrl.prescale_fraction}, r);
      r = nx();
      t = nx();
      wr(4'h8, r);
      wr(4'h9, t);
      rd(4'h9, 1'b0, t);
      chk(ctrl.idle_time, f_idle(t, r));
      chk({5'h00, ctrl.xon_inband_en, ctrl.tx_empty_int_en,
           ctrl.rx_timeout_en}, {5'h00, t[3:1]});
      chk({4'h0, ctrl.sample_clock_value}, {4'h0, t[7:4]});
    end
    for (int b = 0; b < 2; b++) begin
      rxs = b[0];
      txs = !b[0];
      wr(4'h7, 8'h0C);
      chk({7'h00, txl}, {7'h00, rxs});
      wr(4'h7, 8'h04);
      chk({7'h00, txl}, {7'h00, txs});
    end
    flow = 1'b0;
    wr(4'h7, 8'h05);
    chk({7'h00, txa}, 8'h01);
    flow = 1'b1;
    dsr_n = 1'b1;
    wr(4'h7, 8'h86);
    chk({7'h00, txa}, 8'h00);
    @(negedge i_clk);
    chk({6'h00, ctrl.xtal_fb_dis, ctrl.auto_dsr_dtr_en}, 8'h03);
    wr(4'h7, 8'h04);
    chk({7'h00, txa}, 8'h01);
    wr(4'h7, 8'h14);
    @(negedge i_clk);
    chk({7'h00, ctrl.burst_en}, 8'h01);
    wr(4'h8, 8'hA5);
    rd(4'h8, 1'b0, 8'hA5);
    rd(4'h0, 1'b1, t);
    wr(4'h7, 8'h04);
    for (int i = 0; i < 70; i++) begin
      r = nx();
      @(negedge i_clk);
      rxp = 1'b1;
      rxpe = (i < 2) || (i < 60 && r[0]);
      txp = (i < 5);
      errs += int'(rxpe);
    end
    @(negedge i_clk);
    {rxp, rxpe, txp} = '0;
    rd(4'h5, 1'b0, 8'h40);
    for (int i = 0; i < 10; i++) begin
      @(negedge i_clk);
      rxo = 1'b1;
      rxoe = (i < 2);
      txo = (i < 1);
    end
    @(negedge i_clk);
    {rxoe, txo, rxp} = 3'b001;
    @(negedge i_clk);
    {rxo, rxp} = '0;
    rd(4'h5, 1'b0, 8'h36);
    wr(4'h7, 8'h44);
    rd(4'h5, 1'b0, 8'(errs - 2));
    rd(4'h6, 1'b0, 8'h04);
    for (int k = 1; k < 8; k++) begin
      @(negedge i_clk);
      src = 7'h01 << (k - 1);
      @(negedge i_clk);
      src = 7'h00;
      rd(4'hF, 1'b0, 8'h01 << k);
      wr(4'hF, 8'h01);
      rd(4'hF, 1'b0, 8'h00);
    end
    wr(4'hF, 8'hA4);
    rd(4'hF, 1'b0, 8'hA4);
    wr(4'hF, 8'h01);
    wr(4'h4, 8'h10);
    wr(4'h9, 8'h00);
    for (int k = 0; k < 2; k++) begin
      modem7 = k[0];
      r = nx();
      divisor = {15'h0000, r[0]} + 16'h0001;
      n = 0;
      while (!tick && n < 300) begin
        @(negedge i_clk);
        n++;
      end
      n = 0;
      do begin
        @(negedge i_clk);
        n++;
      end while (!tick && n < 300);
      chk(8'(n), f_baud(int'(divisor), 1, k, 0, 0));
    end
    complete_run();
  end
endmodule : uart_special_function_regs_tb
